// ---- hdl/rfc_bank.sv ----
// Receive filter control and management VLAN tag registers with ack timer and interrupt
// Assumes a single-cycle register port master and a receive datapath on i_ref_clk
//
// Overview of operation
// - Storage filter off bit 0 stops storage-protocol header filtering.
// - Bits 5:1 give the storage header length in 32-bit words.
// - Bit 6 stops filtering of file-sharing write request headers.
// - Bit 7 stops filtering of file-sharing read reply headers.
// - Bits 9:8 pick file-sharing version 2, 3, 4, or reserved.
// - Bit 10 disables IPv6 packet filtering.
// - Bit 11 disables checksum processing on IPv6 packets.
// - Bit 12 suppresses the accelerated TCP acknowledgement interrupt.
// - Bit 13 set needs ACK flag and no payload; clear needs ACK only.
// - Bit 14 stops header split of IP fragments.
// - Extended status written when bit 15 set or split descriptors used.
// - Each VLAN entry holds a 12-bit ID, compared only while enabled.
// - Bit 31 enables the VLAN entry and resets to zero.
// - IPv6 L4 checksum only with both IPv6 off bits clear and offload on.
// - Acknowledgements use a dedicated delay timer in 1.024 us units.
`timescale 1ns/10ps
`include "rfc_consts.svh"
module rfc_bank
    import rfc_pkg::*;
#(
    parameter int TICK_CYCLES = `RFC_TICK_CYCLES
)(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [19:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    input wire logic i_l4_checksum_offload_on,
    input wire logic i_split_desc,
    input wire logic i_pkt_valid,
    input wire logic i_pkt_v6,
    input wire logic i_pkt_tcp_ack,
    input wire logic i_pkt_has_payload,
    input wire logic i_pkt_vlan_valid,
    input wire logic [11:0] i_pkt_vlan_id,
    output logic o_storage_filter_on,
    output logic [4:0] o_storage_header_word_count,
    output logic o_fileshare_write_filter_on,
    output logic o_fileshare_read_filter_on,
    output logic [1:0] o_fileshare_version,
    output logic o_v6_filter_on,
    output logic o_v6_l4_checksum_on,
    output logic o_fragment_split_on,
    output logic o_extended_status_on,
    output logic [1:0] o_vlan_match,
    output logic o_ack_irq_pulse
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic [31:0] fctl_r;
    logic [31:0] vlan_r [2];
    logic [15:0] ack_delay_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;
    logic ack_hit;
    logic [1:0] vlan_hit;
    rfc_ack_type ack_pkt;
    rfc_ack_if ack_bus();

    function automatic logic is_addr(input logic [19:0] a, input logic [19:0] off);
        is_addr = (a == off);
    endfunction : is_addr

    function automatic logic vlan_cmp(input logic [31:0] ent, input logic [11:0] id);
        vlan_cmp = ent[`RFC_VLAN_EN] && (ent[`RFC_VLAN_ID_MSB:0] == id);
    endfunction : vlan_cmp

    // Reset released through two flops so all bank flops leave reset together
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            fctl_r <= `RFC_RESET_VAL;
        end
        else if (i_wr && is_addr(i_addr, `RFC_OFF_FILTER_CTRL))
        begin
            fctl_r <= i_wdata & `RFC_FC_MASK;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            vlan_r[0] <= `RFC_RESET_VAL;
            vlan_r[1] <= `RFC_RESET_VAL;
        end
        else if (i_wr)
        begin
            if (is_addr(i_addr, `RFC_OFF_MGMT_VLAN0))
            begin
                vlan_r[0] <= i_wdata & `RFC_VLAN_MASK;
            end
            if (is_addr(i_addr, `RFC_OFF_MGMT_VLAN1))
            begin
                vlan_r[1] <= i_wdata & `RFC_VLAN_MASK;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            ack_delay_r <= 16'h0000;
            irq_mask_r <= 3'h0;
        end
        else if (i_wr)
        begin
            if (is_addr(i_addr, `RFC_OFF_ACK_DELAY))
            begin
                ack_delay_r <= i_wdata[15:0];
            end
            if (is_addr(i_addr, `RFC_OFF_IRQ_MASK))
            begin
                irq_mask_r <= i_wdata[2:0];
            end
        end
    end

    // Control outputs to the receive datapath
    assign o_storage_filter_on = !fctl_r[`RFC_FC_STORAGE_OFF];
    assign o_storage_header_word_count = fctl_r[`RFC_FC_WC_MSB:`RFC_FC_WC_LSB];
    assign o_fileshare_write_filter_on = !fctl_r[`RFC_FC_WR_OFF];
    assign o_fileshare_read_filter_on = !fctl_r[`RFC_FC_RD_OFF];
    assign o_fileshare_version = fctl_r[`RFC_FC_VER_MSB:`RFC_FC_VER_LSB];
    assign o_v6_filter_on = !fctl_r[`RFC_FC_V6_OFF];
    assign o_v6_l4_checksum_on = !fctl_r[`RFC_FC_V6_OFF] && !fctl_r[`RFC_FC_V6_CSUM_OFF]
        && i_l4_checksum_offload_on;
    assign o_fragment_split_on = !fctl_r[`RFC_FC_FRAG_OFF];
    assign o_extended_status_on = fctl_r[`RFC_FC_EXST_ON] || i_split_desc;

    // Acknowledgement recognition; payload test only in the strict mode
    assign ack_pkt = '{valid: i_pkt_valid, ack_flag: i_pkt_tcp_ack,
        has_payload: i_pkt_has_payload};
    assign ack_hit = ack_pkt.valid && ack_pkt.ack_flag && !fctl_r[`RFC_FC_ACK_OFF]
        && !(fctl_r[`RFC_FC_ACK_NOPAY] && ack_pkt.has_payload);
    assign ack_bus.start = ack_hit && !ack_bus.busy;
    assign ack_bus.delay = ack_delay_r;
    assign o_ack_irq_pulse = ack_bus.expire;

    rfc_ack_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rstn(rst_sync_r),
        .ack(ack_bus)
    );

    // Hit is combinational so status and match flop take the same packet at the same edge
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            vlan_hit[i] = i_pkt_valid && i_pkt_vlan_valid && vlan_cmp(vlan_r[i], i_pkt_vlan_id);
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            o_vlan_match <= 2'h0;
        end
        else
        begin
            o_vlan_match <= vlan_hit;
        end
    end

    // Status: bit0 ack timer expiry, bits 2:1 management VLAN hits; set beats read clear
    assign irq_set = {vlan_hit, ack_bus.expire};
    assign irq_clr = (i_rd && is_addr(i_addr, `RFC_OFF_IRQ_STATUS)) ? 3'h7 : 3'h0;

    always_ff @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            irq_stat_r <= 3'h0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign o_irq = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge i_ref_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            o_rdata <= 32'h00000000;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `RFC_OFF_FILTER_CTRL: o_rdata <= fctl_r;
                `RFC_OFF_MGMT_VLAN0: o_rdata <= vlan_r[0];
                `RFC_OFF_MGMT_VLAN1: o_rdata <= vlan_r[1];
                `RFC_OFF_ACK_DELAY: o_rdata <= {16'h0000, ack_delay_r};
                `RFC_OFF_IRQ_STATUS: o_rdata <= {29'h00000000, irq_stat_r};
                `RFC_OFF_IRQ_MASK: o_rdata <= {29'h00000000, irq_mask_r};
                default: o_rdata <= 32'h00000000;
            endcase
        end
        else
        begin
            o_rdata <= 32'h00000000;
        end
    end

    sequence s_fc_write;
        i_wr && is_addr(i_addr, `RFC_OFF_FILTER_CTRL);
    endsequence

    property p_resv_zero;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        s_fc_write |=> (fctl_r[31:16] == 16'h0000) && (fctl_r[15:0] == $past(i_wdata[15:0]));
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("filter ctrl write wrong");

    property p_storage;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        s_fc_write |=> o_storage_filter_on == !$past(i_wdata[0]);
    endproperty
    a_storage: assert property (p_storage) else $error("storage filter wrong");

    property p_wc;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        s_fc_write |=> o_storage_header_word_count == $past(i_wdata[5:1]);
    endproperty
    a_wc: assert property (p_wc) else $error("word count wrong");

    property p_ver;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        s_fc_write |=> o_fileshare_version == $past(i_wdata[9:8]);
    endproperty
    a_ver: assert property (p_ver) else $error("version wrong");

    property p_v6csum;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        (fctl_r[10] || fctl_r[11] || !i_l4_checksum_offload_on) |-> !o_v6_l4_checksum_on;
    endproperty
    a_v6csum: assert property (p_v6csum) else $error("v6 checksum on");

    property p_ackoff;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        fctl_r[12] |-> !ack_bus.start;
    endproperty
    a_ackoff: assert property (p_ackoff) else $error("ack accel while off");

    property p_acknopay;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        (fctl_r[13] && i_pkt_has_payload) |-> !ack_hit;
    endproperty
    a_acknopay: assert property (p_acknopay) else $error("payload ack recognised");

    property p_exst;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        i_split_desc |-> o_extended_status_on;
    endproperty
    a_exst: assert property (p_exst) else $error("extended status off");

    property p_vlan_dis;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        !vlan_r[0][31] |=> !o_vlan_match[0];
    endproperty
    a_vlan_dis: assert property (p_vlan_dis) else $error("disabled vlan matched");

    property p_vlan_hit;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        (i_pkt_valid && i_pkt_vlan_valid && vlan_r[1][31] && vlan_r[1][11:0] == i_pkt_vlan_id)
            |=> o_vlan_match[1];
    endproperty
    a_vlan_hit: assert property (p_vlan_hit) else $error("enabled vlan missed");

    property p_set_wins;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        (irq_set != 3'h0) |=> ((irq_stat_r & $past(irq_set)) == $past(irq_set));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status event lost");

    property p_rd_resv;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        (i_rd && is_addr(i_addr, `RFC_OFF_MGMT_VLAN0)) |=> (o_rdata[30:12] == 19'h00000);
    endproperty
    a_rd_resv: assert property (p_rd_resv) else $error("vlan reserved bits read");

    property p_ack_zero;
        @(posedge i_ref_clk) disable iff (!rst_sync_r)
        (ack_bus.start && ack_delay_r == 16'h0000) |=> o_ack_irq_pulse;
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("immediate ack irq missed");
endmodule : rfc_bank

// ---- hdl/rfc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the receive filter control bank
// Assumes inclusion by bare name from the package and the design modules
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH
`define RFC_ADDR_W 20
`define RFC_OFF_FILTER_CTRL 20'h05008
`define RFC_OFF_MGMT_VLAN0 20'h05010
`define RFC_OFF_MGMT_VLAN1 20'h05014
`define RFC_OFF_ACK_DELAY 20'h05020
`define RFC_OFF_IRQ_STATUS 20'h05024
`define RFC_OFF_IRQ_MASK 20'h05028
`define RFC_FC_STORAGE_OFF 0
`define RFC_FC_WC_LSB 1
`define RFC_FC_WC_MSB 5
`define RFC_FC_WR_OFF 6
`define RFC_FC_RD_OFF 7
`define RFC_FC_VER_LSB 8
`define RFC_FC_VER_MSB 9
`define RFC_FC_V6_OFF 10
`define RFC_FC_V6_CSUM_OFF 11
`define RFC_FC_ACK_OFF 12
`define RFC_FC_ACK_NOPAY 13
`define RFC_FC_FRAG_OFF 14
`define RFC_FC_EXST_ON 15
`define RFC_FC_MASK 32'h0000FFFF
`define RFC_VLAN_MASK 32'h80000FFF
`define RFC_VLAN_EN 31
`define RFC_VLAN_ID_MSB 11
`define RFC_RESET_VAL 32'h00000000
`define RFC_IRQ_W 3
`define RFC_ACK_DELAY_W 16
`define RFC_TICK_NS 1024
`define RFC_CLK_PS 4000
`define RFC_TICK_CYCLES ((`RFC_TICK_NS * 1000) / `RFC_CLK_PS)
`endif

// ---- hdl/rfc_pkg.sv ----
// Types shared by the receive filter control bank
// Assumes the constants header is on the include path
`include "rfc_consts.svh"
package rfc_pkg;
    typedef enum logic [1:0] {RFC_VER2, RFC_VER3, RFC_VER4, RFC_VER_RSVD} rfc_ver_type;
    typedef enum logic [0:0] {RFC_TMR_IDLE, RFC_TMR_RUN} rfc_tmr_type;
    typedef struct packed {
        logic valid;
        logic ack_flag;
        logic has_payload;
    } rfc_ack_type;
endpackage : rfc_pkg

// ---- hdl/rfc_ack_if.sv ----
// Carries acknowledgement detect and timer handshake between bank and timer
// Assumes one clock domain
`timescale 1ns/10ps
`include "rfc_consts.svh"
interface rfc_ack_if;
    logic start;
    logic [`RFC_ACK_DELAY_W-1:0] delay;
    logic expire;
    logic busy;
    modport bank (output start, output delay, input expire, input busy);
    modport tmr (input start, input delay, output expire, output busy);
endinterface : rfc_ack_if

// ---- hdl/rfc_ack_timer.sv ----
// Acknowledgement interrupt delay timer counting in 1.024 us ticks
// Assumes synchronous reset release already done by the top
`timescale 1ns/10ps
`include "rfc_consts.svh"
module rfc_ack_timer
    import rfc_pkg::*;
#(
    parameter int TICK_CYCLES = `RFC_TICK_CYCLES
)(
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    rfc_ack_if.tmr ack
);
    rfc_tmr_type state_r;
    logic [15:0] left_r;
    logic [15:0] tick_r;
    logic tick;
    logic expire_r;

    assign tick = (tick_r == 16'(TICK_CYCLES - 1));
    assign ack.expire = expire_r;
    assign ack.busy = (state_r == RFC_TMR_RUN);

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r <= RFC_TMR_IDLE;
            left_r <= 16'h0000;
            tick_r <= 16'h0000;
            expire_r <= 1'b0;
        end
        else
        begin
            expire_r <= 1'b0;
            case (state_r)
                RFC_TMR_IDLE:
                begin
                    tick_r <= 16'h0000;
                    if (ack.start && ack.delay == 16'h0000)
                    begin
                        expire_r <= 1'b1;
                    end
                    else if (ack.start)
                    begin
                        left_r <= ack.delay;
                        state_r <= RFC_TMR_RUN;
                    end
                end
                RFC_TMR_RUN:
                begin
                    // No reload while counting down
                    tick_r <= tick ? 16'h0000 : tick_r + 16'h0001;
                    if (tick)
                    begin
                        left_r <= left_r - 16'h0001;
                        if (left_r == 16'h0001)
                        begin
                            expire_r <= 1'b1;
                            state_r <= RFC_TMR_IDLE;
                        end
                    end
                end
                default: state_r <= RFC_TMR_IDLE;
            endcase
        end
    end

    property p_tmr_expire_idle;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        expire_r |-> (state_r == RFC_TMR_IDLE);
    endproperty
    a_tmr_expire_idle: assert property (p_tmr_expire_idle) else $error("expire without idle");
endmodule : rfc_ack_timer

// ---- sim/tb_rx_filter_ctrl_mgmt_vlan_regs.sv ----
// Self-checking bench for the receive filter control bank
// Assumes the constants header and the package are compiled first
`timescale 1ns/10ps
`include "rfc_consts.svh"
module tb_rx_filter_ctrl_mgmt_vlan_regs;
    import rfc_pkg::*;
    localparam int TK = 2;
    localparam logic [19:0] FC = `RFC_OFF_FILTER_CTRL;
    localparam logic [19:0] ST = `RFC_OFF_IRQ_STATUS;
    localparam logic [19:0] MK = `RFC_OFF_IRQ_MASK;
    logic clk, rstn, wr, rd, ofl, sp, pv, p6, pa, pp, vv;
    logic [19:0] addr;
    logic [31:0] wd, rdata, d;
    logic [11:0] vid, id;
    logic irq, sf, fw, fr, v6, cs, fs, es, ap;
    logic [4:0] wc;
    logic [1:0] ver, vm;
    logic [13:0] ctl, ec;
    logic [19:0] regs [6];
    int seed = 83;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_pulse = 0;
    int last_pulse = 0;
    int n0, t0;

    assign ctl = {sf, wc, fw, fr, ver, v6, cs, fs, es};

    rfc_bank #(.TICK_CYCLES(TK)) dut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
        .i_l4_checksum_offload_on(ofl), .i_split_desc(sp), .i_pkt_valid(pv),
        .i_pkt_v6(p6), .i_pkt_tcp_ack(pa), .i_pkt_has_payload(pp), .i_pkt_vlan_valid(vv),
        .i_pkt_vlan_id(vid), .o_storage_filter_on(sf), .o_storage_header_word_count(wc),
        .o_fileshare_write_filter_on(fw), .o_fileshare_read_filter_on(fr),
        .o_fileshare_version(ver), .o_v6_filter_on(v6), .o_v6_l4_checksum_on(cs),
        .o_fragment_split_on(fs), .o_extended_status_on(es), .o_vlan_match(vm),
        .o_ack_irq_pulse(ap));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Pulses are one cycle wide, so they are counted rather than polled
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (ap === 1'b1)
        begin
            n_pulse <= n_pulse + 1;
            last_pulse <= cyc;
        end
    end

    function automatic logic [13:0] exp_ctl(logic [31:0] r, logic s, logic o);
        return {~r[0], r[5:1], ~r[6], ~r[7], r[9:8], ~r[10], ~r[10] & ~r[11] & o, ~r[14],
            r[15] | s};
    endfunction : exp_ctl

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task report_and_stop;
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic wrt(input logic [19:0] a, input logic [31:0] v);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wrt

    task automatic rdc(input logic [19:0] a, input logic [31:0] e, input string nm);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
        @(posedge clk);
    endtask : rdc

    // Write then read with no gap, the tightest order the port allows
    task automatic wrd(input logic [19:0] a, input logic [31:0] v, input logic [31:0] e);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("readback", e, rdata);
        @(posedge clk);
    endtask : wrd

    task automatic pkt(input logic a, input logic p, input logic v, input logic [11:0] i,
        input logic [1:0] em);
        pa <= a;
        pp <= p;
        vv <= v;
        vid <= i;
        p6 <= $random(seed);
        pv <= 1'b1;
        @(posedge clk);
        pv <= 1'b0;
        #1;
        chk("vlan match", {30'h0, em}, {30'h0, vm});
        @(posedge clk);
    endtask : pkt

    task automatic wait_pulse(input int n);
        for (int k = 0; k < 200 && n_pulse == n; k++)
            @(posedge clk);
        if (n_pulse == n)
        begin
            $display("unexpected ack pulse: expected 1, seen 0");
            n_fail++;
            report_and_stop();
        end
    endtask : wait_pulse

    initial
    begin
        {wr, rd, ofl, sp, pv, p6, pa, pp, vv, addr, wd, vid} = '0;
        rstn = 1'b1;
        regs = '{FC, `RFC_OFF_MGMT_VLAN0, `RFC_OFF_MGMT_VLAN1, `RFC_OFF_ACK_DELAY, ST, MK};
        // Reset falls after time zero so no reset flop can miss the edge
        #1 rstn = 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("controls", exp_ctl(32'h0, 1'b0, 1'b0), ctl);
        foreach (regs[i])
            rdc(regs[i], 32'h0, "reset value");
        rdc(20'h05018, 32'h0, "unmapped");
        for (int i = 0; i < 24; i++)
        begin
            d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
            d[9:8] = i[1:0];
            sp <= $random(seed);
            ofl <= $random(seed);
            wrd(FC, d, d & `RFC_FC_MASK);
            ec = exp_ctl(d, sp, ofl);
            chk("storage ctl", ec[13:8], ctl[13:8]);
            chk("fileshare ctl", ec[7:4], ctl[7:4]);
            chk("v6 ctl", ec[3:2], ctl[3:2]);
            chk("split ctl", ec[1:0], ctl[1:0]);
        end
        for (int e = 0; e < 2; e++)
        begin
            id = $random(seed);
            wrd(regs[e + 1], {1'b1, 19'h7FFFF, id}, {1'b1, 19'h0, id});
            pkt(1'b0, 1'b0, 1'b1, id, 2'b01 << e);
            pkt(1'b0, 1'b0, 1'b1, id ^ 12'h801, 2'b00);
            wrt(regs[e + 1], {20'h0, id});
            pkt(1'b0, 1'b0, 1'b1, id, 2'b00);
        end
        rdc(ST, 32'h6, "status");
        rdc(ST, 32'h0, "status");
        wrd(MK, 32'hFFFFFFFF, 32'h7);
        wrt(FC, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            d = k * 4;
            wrd(`RFC_OFF_ACK_DELAY, {16'hFFFF, d[15:0]}, d);
            n0 = n_pulse;
            t0 = cyc;
            pkt(1'b1, 1'b0, 1'b0, 12'h0, 2'b00);
            // A second ack mid-countdown must not restart; with no delay there is no countdown
            if (k == 1)
            begin
                repeat (3) @(posedge clk);
                pkt(1'b1, 1'b0, 1'b0, 12'h0, 2'b00);
            end
            wait_pulse(n0);
            t0 = last_pulse - t0;
            chk("ack delay", 1, t0 >= d * TK + 1 && t0 <= d * TK + 5);
            repeat (20) @(posedge clk);
            chk("ack pulses", n0 + 1, n_pulse);
            chk("irq", 1, irq);
            rdc(ST, 32'h1, "status");
            chk("irq", 0, irq);
        end
        for (int c = 0; c < 4; c++)
        begin
            wrt(FC, {18'h0, c >= 2, c == 1, 12'h0});
            n0 = n_pulse;
            pkt(1'b1, c == 0 || c == 2, 1'b0, 12'h0, 2'b00);
            repeat (12) @(posedge clk);
            chk("ack accepted", c == 0 || c == 3, n_pulse - n0);
            rdc(ST, {31'h0, c == 0 || c == 3}, "status");
        end
        wrt(MK, 32'h0);
        pkt(1'b1, 1'b0, 1'b0, 12'h0, 2'b00);
        repeat (12) @(posedge clk);
        chk("masked irq", 0, irq);
        wrd(MK, 32'h1, 32'h1);
        chk("irq", 1, irq);
        rdc(ST, 32'h1, "status");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(FC, 32'h0, "reset again");
        rdc(`RFC_OFF_MGMT_VLAN1, 32'h0, "reset again");
        report_and_stop();
    end
endmodule : tb_rx_filter_ctrl_mgmt_vlan_regs
